// File: hw/dmd_pkg.sv
package dmd_pkg;

   // Address map of the internal and expanded data spaces and of program memory
   localparam logic [7:0]  DMD_LOWER_TOP      = 8'h7f;
   localparam logic [7:0]  DMD_BANK_TOP       = 8'h1f;
   localparam logic [7:0]  DMD_BITRAM_BASE    = 8'h20;
   localparam logic [15:0] DMD_EXPANDED_RAM_TOP       = 16'h02ff;
   localparam logic [15:0] DMD_CODE_TOP       = 16'h1fff;

   // Register offsets in the special-function space
   localparam logic [7:0]  DMD_PTRSEL_OFS     = 8'ha2;
   localparam logic [7:0]  DMD_PAGE_OFS       = 8'h8f;
   localparam logic [7:0]  DMD_PTR_LO_OFS     = 8'h82;
   localparam logic [7:0]  DMD_PTR_HI_OFS     = 8'h83;
   localparam logic [7:0]  DMD_PSW_OFS        = 8'hd0;

   // Field positions and reset values
   localparam int          DMD_PTRSEL_POS     = 0;
   localparam int          DMD_BUSY_POS       = 1;
   localparam int          DMD_DONE_POS       = 0;
   localparam int          DMD_BANK_LO_POS    = 3;
   localparam logic [7:0]  DMD_PTRSEL_RST     = 8'h00;
   localparam logic [7:0]  DMD_PAGE_RST       = 8'h00;
   localparam logic [15:0] DMD_PTR_RST        = 16'h0000;
   localparam logic [7:0]  DMD_PSW_RST        = 8'h00;

   // Kind of internal access
   typedef enum logic [1:0] {
      DMD_ACC_DIRECT,
      DMD_ACC_INDIRECT,
      DMD_ACC_BIT,
      DMD_ACC_REG
   } dmd_mode_type;

   // Target of an internal access
   typedef enum logic [1:0] {
      DMD_TGT_LOWER,
      DMD_TGT_UPPER,
      DMD_TGT_SFR,
      DMD_TGT_NONE
   } dmd_target_type;

   // Pointer operations
   typedef enum logic [2:0] {
      DMD_POP_NONE,
      DMD_POP_INC,
      DMD_POP_LOAD,
      DMD_POP_CODE,
      DMD_POP_XREAD,
      DMD_POP_XWRITE,
      DMD_POP_JUMP
   } dmd_ptrop_type;

   // Internal access request from the core
   typedef struct packed {
      logic         valid;
      dmd_mode_type mode;
      logic [7:0]   addr;
      logic         write;
      logic [7:0]   wdata;
   } dmd_ireq_type;

   // Decoded internal access
   typedef struct packed {
      dmd_target_type target;
      logic [7:0]     addr;
      logic [2:0]     bit_sel;
      logic           bit_access;
      logic           write;
   } dmd_idec_type;

endpackage : dmd_pkg

// File: hw/dmd_decode.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1: Internal data addresses are eight bits, a 256 byte space.
// RULE2: Direct access above 7FH goes to special-function registers.
// RULE3: Indirect access above 7FH goes to separate upper 128 byte RAM.
// RULE4: Lowest 32 bytes are four banks of eight working registers.
// RULE5: Sixteen bytes above banks are bit-addressable, bits 00H to 7FH.
// RULE6: Lower RAM direct or indirect; upper RAM only indirect.
// RULE7: Special registers reached only by direct addressing.
// RULE8: Special registers at addresses ending 0H or 8H are bit-addressable.
// RULE9: 768 bytes expanded RAM at 0000H-02FFH via external moves only.
// RULE10: Register-operand external move: page register high, R0/R1 low.
// RULE11: Paged window is the same storage as 16-bit expanded RAM.
// RULE12: 8K program memory serves fetch and code-read instructions.
// RULE13: Two independent 16-bit data pointers, one select bit.
// RULE14: Select bit 0 chooses pointer zero, 1 pointer one; read/write.
// RULE15: Selected pointer serves inc, load, code read, moves, jump.
// RULE16: 512 byte EEPROM byte-wide; core keeps running while programming.
// RULE17: Busy bit 1 of status register high while programming.
// RULE18: Done bit 0 of control register set when programming ends.
// RULE19: Page register holds two bits; upper bits read zero.
// RULE20: Status word bank bits pick the working register bank.
// RULE21: Expanded RAM beyond 768 bytes: writes ignored, reads zero.
module dmd_decode
   import dmd_pkg::*;
#(
   parameter int EXPANDED_RAM_BYTES = 768,
   parameter int CODE_BYTES = 8192
) (
   input  wire logic          core_clk,
   input  wire logic          rstn,
   // Internal access from the core
   input  wire dmd_ireq_type  ireq,
   output dmd_idec_type       idec,
   output logic               idec_valid,
   // Special register write port and read data
   input  wire logic          sfr_wr,
   input  wire logic [7:0]    sfr_waddr,
   input  wire logic [7:0]    sfr_wdata,
   input  wire logic [7:0]    sfr_raddr,
   output logic [7:0]         sfr_rdata,
   output logic               sfr_rhit,
   // Pointer and expanded RAM accesses
   input  wire dmd_ptrop_type ptr_op,
   input  wire logic [15:0]   ptr_imm,
   input  wire logic [7:0]    acc,
   input  wire logic          xreg_valid,
   input  wire logic          xreg_write,
   input  wire logic          xreg_sel_r1,
   input  wire logic [7:0]    xwdata,
   output logic [15:0]        expanded_ram_addr,
   output logic               expanded_ram_en,
   output logic               expanded_ram_we,
   output logic [7:0]         expanded_ram_wdata,
   input  wire logic [7:0]    expanded_ram_rdata,
   output logic [7:0]         xrd_data,
   output logic [15:0]        code_addr,
   output logic               code_en,
   output logic [15:0]        jump_target,
   output logic               jump_valid,
   // Working register bank lookup
   input  wire logic [2:0]    reg_num,
   output logic [7:0]         reg_addr,
   // EEPROM status from the array
   input  wire logic          ee_prog_active,
   input  wire logic          ee_prog_end,
   input  wire logic          ee_done_clr,
   output logic               eeprom_busy_flag,
   output logic               eeprom_done_flag
);

   logic [15:0] data_pointer_zero_ff;
   logic [15:0] data_pointer_one_ff;
   logic        pointer_select_bit_ff;
   logic [1:0]  checksum_source_ff;
   logic [1:0]  expanded_ram_page_ff;
   logic [7:0]  program_status_word_ff;
   logic        eeprom_done_ff;
   logic [15:0] data_pointer;
   logic [15:0] nxt_ptr;
   logic        ptr_wr_lo;
   logic        ptr_wr_hi;
   logic [7:0]  r0_ff;
   logic [7:0]  r1_ff;
   logic [15:0] xaddr_raw;
   logic        x_in_range;
   logic        x_ptr_acc;
   logic        x_acc;
   logic        x_wr;
   logic        x_rd_pend_ff;
   logic        x_rd_ok_ff;

   // Selected pointer feeds all six pointer instructions
   assign data_pointer = pointer_select_bit_ff ? data_pointer_one_ff
                                               : data_pointer_zero_ff; // [RULE13]

   // Internal address decode; address width fixes 256 locations [RULE1]
   always_comb begin
      idec.addr       = ireq.addr;
      idec.write      = ireq.write;
      idec.bit_sel    = ireq.addr[2:0];
      idec.bit_access = 1'b0;
      idec.target     = DMD_TGT_LOWER;
      idec_valid      = ireq.valid;
      case (ireq.mode)
         DMD_ACC_DIRECT: begin
            if (ireq.addr > DMD_LOWER_TOP) begin
               idec.target = DMD_TGT_SFR; // [RULE2] [RULE7]
            end else begin
               idec.target = DMD_TGT_LOWER; // [RULE6]
            end
         end
         DMD_ACC_INDIRECT: begin
            if (ireq.addr > DMD_LOWER_TOP) begin
               idec.target = DMD_TGT_UPPER; // [RULE3] [RULE6] [RULE7]
            end else begin
               idec.target = DMD_TGT_LOWER;
            end
         end
         DMD_ACC_BIT: begin
            idec.bit_access = 1'b1;
            if (ireq.addr > DMD_LOWER_TOP) begin
               // Bit space above 7FH maps onto 0H/8H registers
               idec.target = DMD_TGT_SFR; // [RULE8]
               idec.addr   = {ireq.addr[7:3], 3'b000};
            end else begin
               idec.target = DMD_TGT_LOWER; // [RULE5]
               idec.addr   = DMD_BITRAM_BASE + {4'h0, ireq.addr[6:3]};
            end
         end
         default: begin
            idec.target = DMD_TGT_LOWER;
            idec.addr   = reg_addr; // [RULE4]
         end
      endcase
   end

   // Bank bits of the status word select the register bank
   assign reg_addr = {3'b000,
                      program_status_word_ff[DMD_BANK_LO_POS +: 2],
                      reg_num}; // [RULE4] [RULE20]

   // Pointer update
   always_comb begin
      nxt_ptr = data_pointer;
      case (ptr_op)
         DMD_POP_INC:  nxt_ptr = data_pointer + 16'h0001; // [RULE15]
         DMD_POP_LOAD: nxt_ptr = ptr_imm;
         default:      nxt_ptr = data_pointer;
      endcase
   end

   assign ptr_wr_lo = sfr_wr && (sfr_waddr == DMD_PTR_LO_OFS);
   assign ptr_wr_hi = sfr_wr && (sfr_waddr == DMD_PTR_HI_OFS);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         data_pointer_zero_ff <= DMD_PTR_RST;
         data_pointer_one_ff  <= DMD_PTR_RST;
      end else if (!pointer_select_bit_ff) begin
         data_pointer_zero_ff <= nxt_ptr; // [RULE13] [RULE14]
         if (ptr_wr_lo) data_pointer_zero_ff[7:0]  <= sfr_wdata;
         if (ptr_wr_hi) data_pointer_zero_ff[15:8] <= sfr_wdata;
      end else begin
         data_pointer_one_ff <= nxt_ptr; // [RULE13] [RULE14]
         if (ptr_wr_lo) data_pointer_one_ff[7:0]  <= sfr_wdata;
         if (ptr_wr_hi) data_pointer_one_ff[15:8] <= sfr_wdata;
      end
   end

   // Control registers in special-function space
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pointer_select_bit_ff  <= DMD_PTRSEL_RST[DMD_PTRSEL_POS];
         checksum_source_ff     <= DMD_PTRSEL_RST[5:4];
         expanded_ram_page_ff   <= DMD_PAGE_RST[1:0];
         program_status_word_ff <= DMD_PSW_RST;
      end else if (sfr_wr) begin
         if (sfr_waddr == DMD_PTRSEL_OFS) begin
            pointer_select_bit_ff <= sfr_wdata[DMD_PTRSEL_POS]; // [RULE14]
            checksum_source_ff    <= sfr_wdata[5:4];
         end else if (sfr_waddr == DMD_PAGE_OFS) begin
            expanded_ram_page_ff <= sfr_wdata[1:0]; // [RULE19]
         end else if (sfr_waddr == DMD_PSW_OFS) begin
            program_status_word_ff <= sfr_wdata; // [RULE20]
         end
      end
   end

   // Shadow of R0/R1 of the active bank, kept from internal writes
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         r0_ff <= 8'h00;
         r1_ff <= 8'h00;
      end else if (ireq.valid && ireq.write &&
                   idec.target == DMD_TGT_LOWER && !idec.bit_access) begin
         if (idec.addr == {reg_addr[7:3], 3'b000}) r0_ff <= ireq.wdata;
         if (idec.addr == {reg_addr[7:3], 3'b001}) r1_ff <= ireq.wdata;
      end
   end

   // Register read-back; unused bits 7:6 and 3:1 of the select register read zero
   always_comb begin
      sfr_rdata = 8'h00;
      sfr_rhit  = 1'b1;
      if (sfr_raddr == DMD_PTRSEL_OFS) begin
         sfr_rdata = {2'b00, checksum_source_ff, 3'b000,
                      pointer_select_bit_ff}; // [RULE14]
      end else if (sfr_raddr == DMD_PAGE_OFS) begin
         sfr_rdata = {6'h00, expanded_ram_page_ff}; // [RULE19]
      end else if (sfr_raddr == DMD_PTR_LO_OFS) begin
         sfr_rdata = data_pointer[7:0];
      end else if (sfr_raddr == DMD_PTR_HI_OFS) begin
         sfr_rdata = data_pointer[15:8];
      end else if (sfr_raddr == DMD_PSW_OFS) begin
         sfr_rdata = program_status_word_ff;
      end else begin
         sfr_rhit = 1'b0;
      end
   end

   // Expanded RAM address: pointer form or paged form on one array
   assign x_ptr_acc = (ptr_op == DMD_POP_XREAD) || (ptr_op == DMD_POP_XWRITE);
   assign x_acc     = x_ptr_acc || xreg_valid;
   assign x_wr      = (ptr_op == DMD_POP_XWRITE) || (xreg_valid && xreg_write);
   assign xaddr_raw = x_ptr_acc ? data_pointer // [RULE15]
                    : {6'h00, expanded_ram_page_ff,
                       xreg_sel_r1 ? r1_ff : r0_ff}; // [RULE10] [RULE11]
   assign x_in_range = xaddr_raw < 16'(EXPANDED_RAM_BYTES); // [RULE9]

   always_comb begin
      expanded_ram_addr  = xaddr_raw;
      expanded_ram_en    = x_acc && x_in_range; // [RULE21]
      expanded_ram_we    = x_wr && x_in_range; // [RULE21]
      expanded_ram_wdata = x_ptr_acc ? acc : xwdata;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         x_rd_pend_ff <= 1'b0;
         x_rd_ok_ff   <= 1'b0;
      end else begin
         x_rd_pend_ff <= x_acc && !x_wr;
         x_rd_ok_ff   <= x_in_range;
      end
   end

   // Reads out of range return zero
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         xrd_data <= 8'h00;
      end else if (x_rd_pend_ff) begin
         xrd_data <= x_rd_ok_ff ? expanded_ram_rdata : 8'h00; // [RULE21]
      end
   end

   // Code reads use the selected pointer plus accumulator
   always_comb begin
      code_addr   = data_pointer + {8'h00, acc}; // [RULE12] [RULE15]
      code_addr   = code_addr & 16'(CODE_BYTES - 1);
      code_en     = (ptr_op == DMD_POP_CODE);
      jump_target = data_pointer + {8'h00, acc};
      jump_valid  = (ptr_op == DMD_POP_JUMP);
   end

   // EEPROM status; core never stalls on programming [RULE16]
   assign eeprom_busy_flag = ee_prog_active; // [RULE17]
   assign eeprom_done_flag = eeprom_done_ff;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         eeprom_done_ff <= 1'b0;
      end else if (ee_prog_end) begin
         eeprom_done_ff <= 1'b1; // [RULE18] set beats clear
      end else if (ee_done_clr) begin
         eeprom_done_ff <= 1'b0;
      end
   end

   a_direct_high_sfr: assert property (@(posedge core_clk) disable iff (!rstn)
      ireq.valid && ireq.mode == DMD_ACC_DIRECT && ireq.addr[7]
      |-> idec.target == DMD_TGT_SFR) // [RULE2]
      else $error("direct high address not routed to registers");
   a_indirect_upper: assert property (@(posedge core_clk) disable iff (!rstn)
      ireq.mode == DMD_ACC_INDIRECT && ireq.addr[7]
      |-> idec.target == DMD_TGT_UPPER) // [RULE3]
      else $error("indirect high address not routed to upper RAM");
   a_bank_addr: assert property (@(posedge core_clk) disable iff (!rstn)
      sfr_wr && sfr_waddr == DMD_PSW_OFS
      |=> reg_addr[4:3] == $past(sfr_wdata[4:3])) // [RULE20]
      else $error("register bank address wrong");
   a_reg_decode: assert property (@(posedge core_clk) disable iff (!rstn)
      ireq.mode == DMD_ACC_REG |-> idec.target == DMD_TGT_LOWER
      && idec.addr[7:5] == 3'b000 && idec.addr[2:0] == reg_num) // [RULE4]
      else $error("register operand decoded wrong");
   a_indirect_no_sfr: assert property (@(posedge core_clk) disable iff (!rstn)
      ireq.mode == DMD_ACC_INDIRECT |-> idec.target != DMD_TGT_SFR) // [RULE7]
      else $error("indirect access reached registers");
   a_bit_lower: assert property (@(posedge core_clk) disable iff (!rstn)
      ireq.mode == DMD_ACC_BIT && !ireq.addr[7]
      |-> idec.addr == 8'h20 + {4'h0, ireq.addr[6:3]}) // [RULE5]
      else $error("bit address maps to wrong byte");
   a_bit_sfr: assert property (@(posedge core_clk) disable iff (!rstn)
      ireq.mode == DMD_ACC_BIT && ireq.addr[7]
      |-> idec.addr[2:0] == 3'b000) // [RULE8]
      else $error("bit register address not 0H or 8H");
   a_ptr_inc: assert property (@(posedge core_clk) disable iff (!rstn)
      ptr_op == DMD_POP_INC && !sfr_wr
      |=> data_pointer == $past(data_pointer) + 16'h0001) // [RULE15]
      else $error("pointer increment wrong");
   a_ptr_other_held: assert property (@(posedge core_clk) disable iff (!rstn)
      pointer_select_bit_ff && $stable(pointer_select_bit_ff)
      |=> $stable(data_pointer_zero_ff)) // [RULE13]
      else $error("unselected pointer changed");
   a_expanded_ram_oob: assert property (@(posedge core_clk) disable iff (!rstn)
      x_acc && xaddr_raw > DMD_EXPANDED_RAM_TOP |-> !expanded_ram_en && !expanded_ram_we
      ##2 ($past(x_wr, 2) || xrd_data == 8'h00)) // [RULE21]
      else $error("out of range expanded RAM access not suppressed");
   a_page_addr: assert property (@(posedge core_clk) disable iff (!rstn)
      xreg_valid && !x_ptr_acc
      |-> expanded_ram_addr[15:8] == {6'h00, expanded_ram_page_ff}) // [RULE10]
      else $error("paged high byte wrong");
   a_done_set: assert property (@(posedge core_clk) disable iff (!rstn)
      ee_prog_end |=> eeprom_done_flag) // [RULE18]
      else $error("done flag not set");
   a_sel_read: assert property (@(posedge core_clk) disable iff (!rstn)
      sfr_wr && sfr_waddr == DMD_PTRSEL_OFS |=> pointer_select_bit_ff
      == $past(sfr_wdata[0])) // [RULE14]
      else $error("pointer select bit not written");

   c_ptr_switch: cover property (@(posedge core_clk) disable iff (!rstn)
      $rose(pointer_select_bit_ff));
   c_paged_write: cover property (@(posedge core_clk) disable iff (!rstn)
      xreg_valid && xreg_write && expanded_ram_we);
   c_oob_read: cover property (@(posedge core_clk) disable iff (!rstn)
      x_acc && !x_wr && !x_in_range);
   c_ee_done: cover property (@(posedge core_clk) disable iff (!rstn)
      ee_prog_end && ee_done_clr);
   c_reg_mode: cover property (@(posedge core_clk) disable iff (!rstn)
      ireq.mode == DMD_ACC_REG && reg_num == 3'h7);

endmodule : dmd_decode
`default_nettype wire

// File: verification/dmd_expanded_ram_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmd_expanded_ram_model
   import dmd_pkg::*;
#(
   parameter int BYTES = 768
) (
   input  wire logic        core_clk,
   input  wire logic [15:0] expanded_ram_addr,
   input  wire logic        expanded_ram_en,
   input  wire logic        expanded_ram_we,
   input  wire logic [7:0]  expanded_ram_wdata,
   output logic [7:0]       expanded_ram_rdata
);
   // One array serves both move forms
   logic [7:0] mem [BYTES];

   initial expanded_ram_rdata = 8'h00;
   always @(posedge core_clk) begin
      if (expanded_ram_en && expanded_ram_addr < 16'(BYTES)) begin
         if (expanded_ram_we) begin
            mem[expanded_ram_addr] <= expanded_ram_wdata;
         end
         expanded_ram_rdata <= expanded_ram_we ? ~expanded_ram_rdata : mem[expanded_ram_addr];
      end else begin
         // Idle bus never repeats the last byte
         expanded_ram_rdata <= ~expanded_ram_rdata;
      end
   end
endmodule : dmd_expanded_ram_model
`default_nettype wire

// File: verification/data_memory_decode_bench.sv
`timescale 1ns/1ps
`default_nettype none
module data_memory_decode_bench
   import dmd_pkg::*;
;
   logic           core_clk, rstn, sfr_wr, sfr_rhit, idec_valid;
   dmd_ireq_type   ireq;
   dmd_idec_type   idec;
   dmd_ptrop_type  ptr_op;
   logic [7:0]     sfr_waddr, sfr_wdata, sfr_raddr, sfr_rdata, acc, xwdata;
   logic [7:0]     expanded_ram_wdata, expanded_ram_rdata, xrd_data, reg_addr, rnd;
   logic [15:0]    ptr_imm, expanded_ram_addr, code_addr, jump_target;
   logic           xreg_valid, xreg_write, xreg_sel_r1, expanded_ram_en, expanded_ram_we;
   logic           code_en, jump_valid, ee_prog_active, ee_prog_end;
   logic           ee_done_clr, eeprom_busy_flag, eeprom_done_flag;
   logic [2:0]     reg_num;
   int             n_errors, checks_done, a, e, rv;
   int             mptr[2];
   int             mmem[768];
   dmd_target_type et;

   dmd_decode dut (
      .core_clk(core_clk), .rstn(rstn), .ireq(ireq), .idec(idec),
      .idec_valid(idec_valid), .sfr_wr(sfr_wr), .sfr_waddr(sfr_waddr),
      .sfr_wdata(sfr_wdata), .sfr_raddr(sfr_raddr), .sfr_rdata(sfr_rdata),
      .sfr_rhit(sfr_rhit), .ptr_op(ptr_op), .ptr_imm(ptr_imm), .acc(acc),
      .xreg_valid(xreg_valid), .xreg_write(xreg_write),
      .xreg_sel_r1(xreg_sel_r1), .xwdata(xwdata), .expanded_ram_addr(expanded_ram_addr),
      .expanded_ram_en(expanded_ram_en), .expanded_ram_we(expanded_ram_we), .expanded_ram_wdata(expanded_ram_wdata),
      .expanded_ram_rdata(expanded_ram_rdata), .xrd_data(xrd_data), .code_addr(code_addr),
      .code_en(code_en), .jump_target(jump_target),
      .jump_valid(jump_valid), .reg_num(reg_num), .reg_addr(reg_addr),
      .ee_prog_active(ee_prog_active), .ee_prog_end(ee_prog_end),
      .ee_done_clr(ee_done_clr), .eeprom_busy_flag(eeprom_busy_flag),
      .eeprom_done_flag(eeprom_done_flag));

   dmd_expanded_ram_model #(.BYTES(768)) far_ram (
      .core_clk(core_clk), .expanded_ram_addr(expanded_ram_addr), .expanded_ram_en(expanded_ram_en),
      .expanded_ram_we(expanded_ram_we), .expanded_ram_wdata(expanded_ram_wdata), .expanded_ram_rdata(expanded_ram_rdata));

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp,
                          input string what);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
      end
   endtask : chk_val

   task automatic chk_tgt(input dmd_target_type got,
                          input dmd_target_type exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: target %s", $time, got.name());
      end
   endtask : chk_tgt

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic sfr_write(input logic [7:0] ad, input logic [7:0] d);
      @(negedge core_clk);
      sfr_wr = 1'b1;
      sfr_waddr = ad;
      sfr_wdata = d;
      @(negedge core_clk);
      sfr_wr = 1'b0;
   endtask : sfr_write

   task automatic sfr_read(input logic [7:0] ad, input bit hit, input int x);
      @(negedge core_clk);
      sfr_raddr = ad;
      #1;
      chk_val(16'(sfr_rhit), 16'(hit), "hit");
      chk_val(16'(sfr_rdata), 16'(x), "sfr data");
   endtask : sfr_read

   task automatic pop(input dmd_ptrop_type op);
      @(negedge core_clk);
      ptr_op = op;
      @(negedge core_clk);
      ptr_op = DMD_POP_NONE;
   endtask : pop

   task automatic xrd(input bit paged, input int ad);
      @(negedge core_clk);
      xreg_valid = paged;
      xreg_write = 1'b0;
      ptr_op = paged ? DMD_POP_NONE : DMD_POP_XREAD;
      #1;
      chk_val(16'(expanded_ram_en), 16'(ad < 768), "read enable");
      @(negedge core_clk);
      xreg_valid = 1'b0;
      ptr_op = DMD_POP_NONE;
      @(negedge core_clk);
      #1;
      chk_val(16'(xrd_data), 16'(ad < 768 ? mmem[ad] : 0), "xrd");
   endtask : xrd

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   initial begin
      #500us;
      n_errors++;
      $display("wrong value at %0t: run hung", $time);
      finish_test();
   end

   initial begin
      {rstn, sfr_wr, xreg_valid, xreg_write, xreg_sel_r1} = '0;
      {ee_prog_active, ee_prog_end, ee_done_clr} = '0;
      {sfr_waddr, sfr_wdata, sfr_raddr, acc, xwdata, reg_num} = '0;
      ireq = '0;
      ptr_op = DMD_POP_NONE;
      ptr_imm = 16'h0000;
      rnd = 8'h4e;
      n_errors = 0;
      checks_done = 0;
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      rstn = 1'b1;
      foreach (mptr[i]) mptr[i] = 0;
      sfr_read(8'ha2, 1, 0);
      sfr_read(8'h8f, 1, 0);
      sfr_read(8'h82, 1, 0);
      sfr_read(8'h83, 1, 0);
      sfr_read(8'hd0, 1, 0);
      sfr_read(8'h81, 0, 0);
      chk_val(16'(xrd_data), 16'h0000, "xrd reset");
      $display("test reset done");
      for (int i = 0; i < 30; i++) begin
         rnd = lfsr(rnd);
         a = (i < 6) ? 'h7f + i / 3 : int'(rnd);
         @(negedge core_clk);
         ireq = '{1'b1, dmd_mode_type'(i % 3), 8'(a), rnd[0], 8'h00};
         #1;
         if (i % 3 == 2) begin
            et = (a < 128) ? DMD_TGT_LOWER : DMD_TGT_SFR;
            e = (a < 128) ? 32 + a / 8 : a & 'hf8;
            chk_val(16'(idec.bit_sel), 16'(a % 8), "bit");
         end else begin
            et = (a < 128) ? DMD_TGT_LOWER :
                 (i % 3 == 0) ? DMD_TGT_SFR : DMD_TGT_UPPER;
            e = a;
         end
         chk_tgt(idec.target, et);
         chk_val(16'(idec.addr), 16'(e), "addr");
         chk_val(16'(idec.bit_access), 16'(i % 3 == 2), "bit");
         chk_val(16'(idec_valid), 16'h0001, "valid");
         chk_val(16'(idec.write), 16'(rnd[0]), "write");
      end
      ireq.valid = 1'b0;
      $display("test decode done");
      for (int b = 0; b < 4; b++) begin
         sfr_write(8'hd0, 8'(b << 3));
         sfr_read(8'hd0, 1, b << 3);
         for (int r = 0; r < 8; r++) begin
            @(negedge core_clk);
            reg_num = 3'(r);
            ireq.mode = DMD_ACC_REG;
            #1;
            chk_val(16'(reg_addr), 16'(b * 8 + r), "reg");
            chk_val(16'(idec.addr), 16'(b * 8 + r), "rdec");
            chk_tgt(idec.target, DMD_TGT_LOWER);
         end
      end
      $display("test banks done");
      for (int s = 0; s < 2; s++) begin
         sfr_write(8'ha2, s ? 8'h31 : 8'h0c);
         sfr_read(8'ha2, 1, s ? 'h31 : 0);
         rnd = lfsr(rnd);
         ptr_imm = s ? 16'hffff : {rnd, lfsr(rnd)};
         mptr[s] = ptr_imm;
         pop(DMD_POP_LOAD);
      end
      for (int s = 0; s < 2; s++) begin
         sfr_write(8'ha2, 8'(s));
         sfr_read(8'h82, 1, mptr[s] & 'hff);
         sfr_read(8'h83, 1, mptr[s] >> 8);
         pop(DMD_POP_INC);
         mptr[s] = (mptr[s] + 1) & 'hffff;
         rnd = lfsr(rnd);
         sfr_write(8'h82, rnd);
         mptr[s] = (mptr[s] & 'hff00) | rnd;
         sfr_read(8'h83, 1, mptr[s] >> 8);
         sfr_read(8'h82, 1, mptr[s] & 'hff);
         @(negedge core_clk);
         acc = lfsr(rnd);
         ptr_op = DMD_POP_CODE;
         #1;
         chk_val(16'(code_en), 16'h0001, "code en");
         chk_val(code_addr, 16'((mptr[s] + acc) & 'h1fff), "code");
         @(negedge core_clk);
         ptr_op = DMD_POP_JUMP;
         #1;
         chk_val(16'(jump_valid), 16'h0001, "jump en");
         chk_val(jump_target, 16'(mptr[s] + acc), "jump");
         @(negedge core_clk);
         ptr_op = DMD_POP_NONE;
      end
      $display("test pointers done");
      for (int k = 0; k < 6; k++) begin
         rnd = lfsr(rnd);
         a = (k == 0) ? 'h2ff : (k == 1) ? 'h300 : (k == 2) ? 'hffff :
             ({rnd, lfsr(rnd)} % 768);
         ptr_imm = 16'(a);
         pop(DMD_POP_LOAD);
         @(negedge core_clk);
         acc = rnd;
         ptr_op = DMD_POP_XWRITE;
         #1;
         chk_val(16'(expanded_ram_we), 16'(a < 768), "we");
         if (a < 768) begin
            chk_val(expanded_ram_addr, 16'(a), "xaddr");
            chk_val(16'(expanded_ram_wdata), 16'(acc), "xwdata");
            mmem[a] = acc;
         end
         xrd(1'b0, a);
      end
      $display("test expanded ram done");
      sfr_write(8'h8f, 8'h02);
      sfr_read(8'h8f, 1, 2);
      sfr_write(8'hd0, 8'h08);
      for (int s = 0; s < 2; s++) begin
         rnd = lfsr(rnd);
         rv = rnd;
         @(negedge core_clk);
         ireq = '{1'b1, DMD_ACC_DIRECT, 8'(8 + s), 1'b1, rnd};
         @(negedge core_clk);
         ireq.valid = 1'b0;
         rnd = lfsr(rnd);
         xreg_valid = 1'b1;
         xreg_write = 1'b1;
         xreg_sel_r1 = 1'(s);
         xwdata = rnd;
         #1;
         chk_val(expanded_ram_addr, 16'('h200 + rv), "paged addr");
         chk_val(16'(expanded_ram_we), 16'h0001, "paged we");
         mmem['h200 + rv] = rnd;
         @(negedge core_clk);
         xreg_valid = 1'b0;
         ptr_imm = 16'('h200 + rv);
         pop(DMD_POP_LOAD);
         xrd(1'b0, 'h200 + rv);
         xrd(1'b1, 'h200 + rv);
      end
      $display("test paged done");
      @(negedge core_clk);
      ee_prog_active = 1'b1;
      #1;
      chk_val(16'(eeprom_busy_flag), 16'h0001, "busy");
      chk_val(16'(eeprom_done_flag), 16'h0000, "done");
      sfr_write(8'ha2, 8'h01);
      sfr_read(8'ha2, 1, 1);
      @(negedge core_clk);
      ee_prog_end = 1'b1;
      @(negedge core_clk);
      ee_prog_end = 1'b0;
      ee_prog_active = 1'b0;
      #1;
      chk_val(16'(eeprom_busy_flag), 16'h0000, "idle");
      chk_val(16'(eeprom_done_flag), 16'h0001, "done");
      @(negedge core_clk);
      {ee_prog_end, ee_done_clr} = 2'b11;
      @(negedge core_clk);
      {ee_prog_end, ee_done_clr} = 2'b01;
      #1;
      chk_val(16'(eeprom_done_flag), 16'h0001, "set wins");
      @(negedge core_clk);
      ee_done_clr = 1'b0;
      #1;
      chk_val(16'(eeprom_done_flag), 16'h0000, "cleared");
      $display("test eeprom done");
      finish_test();
   end
endmodule : data_memory_decode_bench
`default_nettype wire
